// file: cmp_cfg.svh
// Purpose: constants for the dual comparator control block
// Assumes: 8-bit special-function-register style access
// Notes:   offsets index the four control/mode registers
`ifndef CMP_CFG_SVH
`define CMP_CFG_SVH

// ****************************************
// register addresses
// ****************************************
`define CMP_ADDR_W        8
`define CMP0_CONTROL_ADDR 8'h88
`define CMP0_MODE_ADDR    8'h89
`define CMP1_CONTROL_ADDR 8'h8A
`define CMP1_MODE_ADDR    8'h8B

// ****************************************
// control register fields
// ****************************************
`define CTL_ENABLE_BIT 7
`define CTL_STATE_BIT  6
`define CTL_RISE_BIT   5
`define CTL_FALL_BIT   4
`define CTL_HYP_HI     3
`define CTL_HYP_LO     2
`define CTL_HYN_HI     1
`define CTL_HYN_LO     0
`define CTL_RESET      8'h00

// ****************************************
// mode register fields
// ****************************************
`define MD_RISE_IE_BIT 5
`define MD_FALL_IE_BIT 4
`define MD_RESP_HI     1
`define MD_RESP_LO     0
`define MD_RESP_RESET  2'h2

`endif

// file: cmp_channel.sv
// Purpose: synchroniser, edge flags and gating for one comparator
// Assumes: raw output is asynchronous to clk
// Notes:   edge flags set wins over software clear
`timescale 1ns/1ps
module cmp_channel
  import cmp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // channel bundle
  cmp_channel_if.chan ch
);

  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       stable;
  logic       rise;
  logic       fall;

  // ****************************************
  // synchroniser
  // ****************************************
  // three flops; a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= ch.rawOut;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // filtered level; holds while the two later stages disagree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stable <= 1'b0;
    end else if (sync2 == sync3) begin
      stable <= sync3;
    end
  end

  // single-cycle edge strikes off the filtered level
  assign rise = (sync2 == sync3) && sync3 && !stable;
  assign fall = (sync2 == sync3) && !sync3 && stable;

  // live state; a disabled core reads low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ch.state <= 1'b0;
    end else begin
      ch.state <= stable & ch.enable;
    end
  end

  // ****************************************
  // sticky edge flags
  // ****************************************
  // set beats clear so an edge in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ch.riseFlag <= 1'b0;
      ch.fallFlag <= 1'b0;
    end else begin
      if (rise && ch.enable) begin
        ch.riseFlag <= 1'b1;
      end else if (ch.clrRise) begin
        ch.riseFlag <= 1'b0;
      end
      if (fall && ch.enable) begin
        ch.fallFlag <= 1'b1;
      end else if (ch.clrFall) begin
        ch.fallFlag <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupt and routed output
  // ****************************************
  // level request while an enabled flag stands; dead when disabled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ch.irq       <= 1'b0;
      ch.routedOut <= 1'b0;
    end else begin
      ch.irq <= ch.enable &&
                ((ch.riseIe && ch.riseFlag) || (ch.fallIe && ch.fallFlag));
      ch.routedOut <= stable & ch.enable;
    end
  end

endmodule

// file: cmp_channel_if.sv
// Purpose: bundle between the top and one comparator channel
// Assumes: single clock domain
// Notes:   top drives config and strobes, channel returns state
`timescale 1ns/1ps
interface cmp_channel_if;
  logic              enable;
  logic              riseIe;
  logic              fallIe;
  logic              clrRise;
  logic              clrFall;
  logic              rawOut;
  logic              state;
  logic              riseFlag;
  logic              fallFlag;
  logic              irq;
  logic              routedOut;

  modport ctrl (output enable, riseIe, fallIe, clrRise, clrFall, rawOut,
                input  state, riseFlag, fallFlag, irq, routedOut);
  modport chan (input  enable, riseIe, fallIe, clrRise, clrFall, rawOut,
                output state, riseFlag, fallFlag, irq, routedOut);
endinterface

// file: cmp_core_model.sv
// Purpose: behavioural analog comparator core
// Assumes: level is the sign of plus minus minus
// Notes:   slower response select means a longer delay
`timescale 1ns/1ps
module cmp_core_model (
  // clock
  input wire logic       clk,
  // controls from the block
  input wire logic       enable,
  input wire logic [1:0] speed,
  // input condition and output
  input wire logic       level,
  output logic           rawOut
);
  logic [3:0] pipe = 4'h0;
  logic       junk = 1'b0;
  // delay line; junk toggles so a dead core never looks settled
  always_ff @(posedge clk) begin
    pipe <= {pipe[2:0], level};
    junk <= ~junk;
  end
  assign rawOut = enable ? pipe[speed] : junk;
endmodule

// file: cmp_dual_assertions.sv
// Purpose: port checks for the comparator control block
// Assumes: one clock, sync active-low reset
// Notes:   config outputs may lag a write by one or two edges
`timescale 1ns/1ps
module cmp_dual_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // comparator side
  input wire logic       cmp0Enable,
  input wire logic       cmp1Enable,
  input wire logic [1:0] cmp0PosHysteresis,
  input wire logic [1:0] cmp0NegHysteresis,
  input wire logic [1:0] cmp1ResponseSelect,
  input wire logic       cmp0RoutedOut,
  input wire logic       cmp1RoutedOut,
  input wire logic       cmp0Irq,
  input wire logic       cmp1Irq,
  input wire logic       cmp0ResetSource
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // read data must not linger outside its slot
  idle_rdata_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not idle");
  enable0_follow_a: assert property (regWr && regAddr == 8'h88 ##1 !regWr
    |=> cmp0Enable == $past(regWdata[7], 2)) else $error("enable 0 wrong");
  enable1_follow_a: assert property (regWr && regAddr == 8'h8A ##1 !regWr
    |=> cmp1Enable == $past(regWdata[7], 2)) else $error("enable 1 wrong");
  hyst0_follow_a: assert property (regWr && regAddr == 8'h88 ##1 !regWr
    |=> {cmp0PosHysteresis, cmp0NegHysteresis} == $past(regWdata[3:0], 2))
    else $error("hysteresis 0 wrong");
  resp1_follow_a: assert property (regWr && regAddr == 8'h8B ##1 !regWr
    |=> cmp1ResponseSelect == $past(regWdata[1:0], 2)) else $error("response 1 wrong");
  // both enables off must silence the interrupt three edges on (mode, channel, output flops)
  irq_gate_a: assert property (regWr && regAddr == 8'h89 && regWdata[5:4] == 2'b00
    |-> ##3 !cmp0Irq) else $error("irq not gated");
  off0_quiet_a: assert property (!cmp0Enable && !$past(cmp0Enable)
    |-> !cmp0RoutedOut && !cmp0Irq) else $error("disabled 0 active");
  off1_quiet_a: assert property (!cmp1Enable && !$past(cmp1Enable)
    |-> !cmp1RoutedOut && !cmp1Irq) else $error("disabled 1 active");
  reset_src_a: assert property ($rose(cmp0RoutedOut) |-> ##[0:1] cmp0ResetSource)
    else $error("reset source missing");
  irq_sticky_a: assert property (cmp1Irq && !regWr && !$past(regWr) && !$past(regWr, 2)
    |=> cmp1Irq) else $error("irq dropped alone");
endmodule

bind dual_comparator_control cmp_dual_assertions i_chk (
  .clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
  .cmp0Enable, .cmp1Enable, .cmp0PosHysteresis, .cmp0NegHysteresis,
  .cmp1ResponseSelect, .cmp0RoutedOut, .cmp1RoutedOut, .cmp0Irq, .cmp1Irq,
  .cmp0ResetSource
);

// file: cmp_pkg.sv
// Purpose: shared types for the comparator control block
// Assumes: cmp_cfg.svh holds all numeric constants
// Notes:   types only
package cmp_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] sel2_t;
endpackage

// file: dual_comparator_control.sv
// Purpose: register front end and control for two analog comparators
// Assumes: plain strobe register port, read data one cycle after strobe
// Notes:   analog cores sit outside; only their digital controls live here
`timescale 1ns/1ps

`include "cmp_cfg.svh"

// Summary of operation
// - control bit 7 powers comparator up when 1, down when 0
// - control bit 6 reads live comparator output while enabled, zero while disabled
// - control bit 5 sets on every low-to-high output transition while enabled
// - control bit 4 sets on every high-to-low output transition while enabled
// - edge flags stay set until software writes them to zero
// - interrupt may come from rising, falling or both edges
// - mode bits 5 and 4 enable rising and falling interrupts
// - mode bits 1..0 pick response time versus supply current
// - control bits 3..0 hold hysteresis and drive the analog core
// - bits 3..2 select positive-going hysteresis amount
// - bits 1..0 select negative hysteresis amount or disable it
// - disabled comparator drives routed output low, no interrupt
// - comparator 1 mirrors comparator 0 but is no reset source
// - comparator 0 output may be offered as a reset source
module dual_comparator_control
  import cmp_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // register port
  input  wire logic [`CMP_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [7:0]              regRdata,
  // analog comparator cores
  input  wire logic                    cmp0Raw,
  input  wire logic                    cmp1Raw,
  output logic                         cmp0Enable,
  output logic                         cmp1Enable,
  output logic      [1:0]              cmp0PosHysteresis,
  output logic      [1:0]              cmp0NegHysteresis,
  output logic      [1:0]              cmp1PosHysteresis,
  output logic      [1:0]              cmp1NegHysteresis,
  output logic      [1:0]              cmp0ResponseSelect,
  output logic      [1:0]              cmp1ResponseSelect,
  // crossbar, interrupt and reset unit
  output logic                         cmp0RoutedOut,
  output logic                         cmp1RoutedOut,
  output logic                         cmp0Irq,
  output logic                         cmp1Irq,
  output logic                         cmp0ResetSource
);

  cmp_channel_if ch0 ();
  cmp_channel_if ch1 ();

  sel2_t hyp0;
  sel2_t hyn0;
  sel2_t hyp1;
  sel2_t hyn1;
  sel2_t resp0;
  sel2_t resp1;
  logic  en0;
  logic  en1;
  logic  rie0;
  logic  fie0;
  logic  rie1;
  logic  fie1;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic hit(input logic [`CMP_ADDR_W-1:0] a,
                               input logic [`CMP_ADDR_W-1:0] target);
    hit = (a == target);
  endfunction

  // control byte as software sees it
  function automatic byte_t ctl_byte(input logic en, input logic st,
                                     input logic rf, input logic ff,
                                     input sel2_t hp, input sel2_t hn);
    ctl_byte = {en, st, rf, ff, hp, hn};
  endfunction

  // mode byte; unused bits read zero
  function automatic byte_t md_byte(input logic ri, input logic fi,
                                    input sel2_t rs);
    md_byte = {2'h0, ri, fi, 2'h0, rs};
  endfunction

  // ****************************************
  // control registers
  // ****************************************
  // enable and hysteresis fields; state and flags handled in channels
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en0  <= 1'b0;
      hyp0 <= 2'h0;
      hyn0 <= 2'h0;
    end else if (regWr && hit(regAddr, `CMP0_CONTROL_ADDR)) begin
      en0  <= regWdata[`CTL_ENABLE_BIT];
      hyp0 <= regWdata[`CTL_HYP_HI:`CTL_HYP_LO];
      hyn0 <= regWdata[`CTL_HYN_HI:`CTL_HYN_LO];
    end
  end

  // second comparator, same layout
  always_ff @(posedge clk) begin
    if (!rstn) begin
      en1  <= 1'b0;
      hyp1 <= 2'h0;
      hyn1 <= 2'h0;
    end else if (regWr && hit(regAddr, `CMP1_CONTROL_ADDR)) begin
      en1  <= regWdata[`CTL_ENABLE_BIT];
      hyp1 <= regWdata[`CTL_HYP_HI:`CTL_HYP_LO];
      hyn1 <= regWdata[`CTL_HYN_HI:`CTL_HYN_LO];
    end
  end

  // ****************************************
  // mode registers
  // ****************************************
  // response time resets to mode 2, interrupts off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rie0  <= 1'b0;
      fie0  <= 1'b0;
      resp0 <= `MD_RESP_RESET;
    end else if (regWr && hit(regAddr, `CMP0_MODE_ADDR)) begin
      rie0  <= regWdata[`MD_RISE_IE_BIT];
      fie0  <= regWdata[`MD_FALL_IE_BIT];
      resp0 <= regWdata[`MD_RESP_HI:`MD_RESP_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rie1  <= 1'b0;
      fie1  <= 1'b0;
      resp1 <= `MD_RESP_RESET;
    end else if (regWr && hit(regAddr, `CMP1_MODE_ADDR)) begin
      rie1  <= regWdata[`MD_RISE_IE_BIT];
      fie1  <= regWdata[`MD_FALL_IE_BIT];
      resp1 <= regWdata[`MD_RESP_HI:`MD_RESP_LO];
    end
  end

  // ****************************************
  // channel wiring
  // ****************************************
  // a flag clears only when software writes a zero to it; writing 1 is
  // ignored so hardware alone can raise it
  assign ch0.enable  = en0;
  assign ch0.riseIe  = rie0;
  assign ch0.fallIe  = fie0;
  assign ch0.rawOut  = cmp0Raw;
  assign ch0.clrRise = regWr && hit(regAddr, `CMP0_CONTROL_ADDR)
                       && !regWdata[`CTL_RISE_BIT];
  assign ch0.clrFall = regWr && hit(regAddr, `CMP0_CONTROL_ADDR)
                       && !regWdata[`CTL_FALL_BIT];
  assign ch1.enable  = en1;
  assign ch1.riseIe  = rie1;
  assign ch1.fallIe  = fie1;
  assign ch1.rawOut  = cmp1Raw;
  assign ch1.clrRise = regWr && hit(regAddr, `CMP1_CONTROL_ADDR)
                       && !regWdata[`CTL_RISE_BIT];
  assign ch1.clrFall = regWr && hit(regAddr, `CMP1_CONTROL_ADDR)
                       && !regWdata[`CTL_FALL_BIT];

  cmp_channel u_ch0 (
    .clk  (clk),
    .rstn (rstn),
    .ch   (ch0)
  );

  cmp_channel u_ch1 (
    .clk  (clk),
    .rstn (rstn),
    .ch   (ch1)
  );

  // ****************************************
  // read port
  // ****************************************
  // data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `CMP0_CONTROL_ADDR: regRdata <= ctl_byte(en0, ch0.state, ch0.riseFlag,
                                                 ch0.fallFlag, hyp0, hyn0);
        `CMP1_CONTROL_ADDR: regRdata <= ctl_byte(en1, ch1.state, ch1.riseFlag,
                                                 ch1.fallFlag, hyp1, hyn1);
        `CMP0_MODE_ADDR:    regRdata <= md_byte(rie0, fie0, resp0);
        `CMP1_MODE_ADDR:    regRdata <= md_byte(rie1, fie1, resp1);
        default:            regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ****************************************
  // analog and system outputs
  // ****************************************
  // registered copies keep every output straight off a flop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp0Enable         <= 1'b0;
      cmp1Enable         <= 1'b0;
      cmp0PosHysteresis  <= 2'h0;
      cmp0NegHysteresis  <= 2'h0;
      cmp1PosHysteresis  <= 2'h0;
      cmp1NegHysteresis  <= 2'h0;
      cmp0ResponseSelect <= `MD_RESP_RESET;
      cmp1ResponseSelect <= `MD_RESP_RESET;
    end else begin
      cmp0Enable         <= en0;
      cmp1Enable         <= en1;
      cmp0PosHysteresis  <= hyp0;
      cmp0NegHysteresis  <= hyn0;
      cmp1PosHysteresis  <= hyp1;
      cmp1NegHysteresis  <= hyn1;
      cmp0ResponseSelect <= resp0;
      cmp1ResponseSelect <= resp1;
    end
  end

  // crossbar, interrupt and reset-unit feeds; the reset unit decides
  // whether to use the comparator, channel one has no such feed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp0RoutedOut   <= 1'b0;
      cmp1RoutedOut   <= 1'b0;
      cmp0Irq         <= 1'b0;
      cmp1Irq         <= 1'b0;
      cmp0ResetSource <= 1'b0;
    end else begin
      cmp0RoutedOut   <= ch0.routedOut;
      cmp1RoutedOut   <= ch1.routedOut;
      cmp0Irq         <= ch0.irq;
      cmp1Irq         <= ch1.irq;
      cmp0ResetSource <= ch0.routedOut;
    end
  end

endmodule

// file: dual_comparator_control_bench.sv
// Purpose: self-checking bench for the dual comparator control block
// Assumes: model cores echo a bench level after a short delay
// Notes:   flags reset to zero, so the model starts with them cleared
`timescale 1ns/1ps
`include "cmp_cfg.svh"
module dual_comparator_control_bench import cmp_pkg::*;;
  logic        clk, rstn, regWr, regRd, rsrc;
  byte_t       regAddr, regWdata, regRdata;
  logic [1:0]  lvl, raw, en, irq, rout, rf, ff;
  sel2_t       hp0, hn0, hp1, hn1, rs0, rs1;
  byte_t       ctl [2];
  byte_t       md [2];
  int          errors, checks, cyc;
  logic [31:0] seed;

  // ****************
  // design and cores
  // ****************
  dual_comparator_control i_dut (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .cmp0Raw(raw[0]), .cmp1Raw(raw[1]), .cmp0Enable(en[0]), .cmp1Enable(en[1]),
    .cmp0PosHysteresis(hp0), .cmp0NegHysteresis(hn0),
    .cmp1PosHysteresis(hp1), .cmp1NegHysteresis(hn1),
    .cmp0ResponseSelect(rs0), .cmp1ResponseSelect(rs1),
    .cmp0RoutedOut(rout[0]), .cmp1RoutedOut(rout[1]),
    .cmp0Irq(irq[0]), .cmp1Irq(irq[1]), .cmp0ResetSource(rsrc)
  );
  cmp_core_model i_core0 (.clk(clk), .enable(en[0]), .speed(rs0), .level(lvl[0]),
    .rawOut(raw[0]));
  cmp_core_model i_core1 (.clk(clk), .enable(en[1]), .speed(rs1), .level(lvl[1]),
    .rawOut(raw[1]));

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic byte_t ctlAddr(input int i);
    return i ? `CMP1_CONTROL_ADDR : `CMP0_CONTROL_ADDR;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (e !== s) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // bus cycles start just after an edge and leave a gap behind them
  task automatic wr(input byte_t a, input byte_t d);
    int i;
    i = (a == 8'h8A || a == 8'h8B);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
    // model: writing 0 clears a flag, writing 1 keeps it
    if (a == 8'h88 || a == 8'h8A) begin
      ctl[i] = {d[7], 3'b000, d[3:0]};
      rf[i] = rf[i] & d[5];
      ff[i] = ff[i] & d[4];
    end
    if (a == 8'h89 || a == 8'h8B)
      md[i] = {2'b00, d[5:4], 2'b00, d[1:0]};
    @(posedge clk);
  endtask
  task automatic rd(input byte_t a, input byte_t e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1 chk("rdata", e, regRdata);
    @(posedge clk);
  endtask
  // edges count only while the core is powered
  task automatic lv(input int i, input logic v);
    if (ctl[i][7] && v != lvl[i] && v)
      rf[i] = 1'b1;
    if (ctl[i][7] && v != lvl[i] && !v)
      ff[i] = 1'b1;
    lvl[i] <= v;
    repeat (14) @(posedge clk);
  endtask
  task automatic look(input int i);
    byte_t e;
    e = ctl[i] | {1'b0, ctl[i][7] & lvl[i], rf[i], ff[i], 4'h0};
    rd(ctlAddr(i), e);
    rd(ctlAddr(i) + 8'h01, md[i]);
    chk("irq", ctl[i][7] & (md[i][5] & rf[i] | md[i][4] & ff[i]), irq[i]);
    chk("routed", ctl[i][7] & lvl[i], rout[i]);
    chk("enable", ctl[i][7], en[i]);
    chk("hyst", ctl[i][3:0], i ? {hp1, hn1} : {hp0, hn0});
    chk("resp", md[i][1:0], i ? rs1 : rs0);
    if (i == 0)
      chk("rsrc", ctl[0][7] & lvl[0], rsrc);
  endtask

  // ****************
  // clock, watchdog, sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    {rstn, regWr, regRd, regAddr, regWdata, lvl, rf, ff} = '0;
    {errors, checks, cyc} = '0;
    seed = 32'h9319;
    ctl = '{8'h00, 8'h00};
    md = '{8'h02, 8'h02};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    look(0);
    look(1);
    wr(8'h8C, 8'hFF); // unmapped write ignored
    rd(8'h8C, 8'h00); // unmapped read
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      wr(ctlAddr(i), {4'h8, seed[3:0]});
      repeat (10) @(posedge clk);
      wr(ctlAddr(i), {4'h8, seed[3:0]});
      wr(ctlAddr(i) + 8'h01, {6'h0C, seed[5:4]});
      look(i);
      lv(i, 1'b1);
      look(i);
      lv(i, 1'b0);
      look(i);
      wr(ctlAddr(i), {4'hB, seed[3:0]});
      look(i);
      wr(ctlAddr(i), {4'h9, seed[3:0]});
      look(i);
      // both enables off while the fall flag stands: the request must drop
      wr(ctlAddr(i) + 8'h01, {6'h00, seed[7:6]});
      look(i);
      wr(ctlAddr(i) + 8'h01, {6'h08, seed[7:6]});
      look(i);
      wr(ctlAddr(i), {4'h0, seed[3:0]});
      lv(i, 1'b1);
      lv(i, 1'b0);
      look(i);
    end
    close_out();
  end
endmodule
